// *** sbu_bridge.sv ***
// serial bridge with rts/cts handshake and wishbone register access
//
// Summary of operation
// R1 - reset gives 115200 baud, 8N1, handshake off with inputs ignored.
// R2 - baud rate programmable between 9600 and 921600 bits per second; the divisor clamp of 21 to 2083 allows up to about 952381.
// R3 - handshake mode: off, hold-off only, gating only, or both.
// R4 - hold-off drops clear-to-send while the receive buffer is full.
// R5 - target stops sending new bytes while clear-to-send is low.
// R6 - gating stops new transmissions while target request-to-send is low.
// R7 - a byte already shifting finishes; target accepts one more character.
// R8 - gating off: request-to-send ignored, queued data sent anyway.
// R9 - mode off: clear-to-send undriven, request-to-send ignored.
// R10 - hold-off only: drive clear-to-send, ignore request-to-send.
// R11 - gating only: clear-to-send undriven, send only while request asserted.
// R12 - both: drive clear-to-send and gate transmission on request-to-send.
// R13 - data passes only while the interface enable is high.
// R14 - attached socket client has priority; usb path then fully idle.
// R15 - with gating on, target must actively drive request-to-send.
// R16 - idle high, low start, eight data bits lsb first, high stop.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "sbu_consts.svh"
module sbu_bridge (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// target link
	input wire logic TGT_RXD,
	output logic TGT_TXD,
	input wire logic TGT_RTS,
	output logic TGT_CTS_O,
	output logic TGT_CTS_OE,
	input wire logic TGT_ENABLE
);

	sbu_pkg::sbu_top_s s_r;
	sbu_pkg::sbu_top_s s_nxt;
	sbu_pkg::sbu_byte_s rx_got;

	logic req;
	logic wr;
	logic rd;
	logic usb_sel;
	logic sock_sel;
	logic path_sel;
	logic gate_on;
	logic tx_go;
	logic [31:0] div_wr;
	logic [31:0] stat;
	logic [31:0] rd_val;

	sbu_rx u_rx (
		.clk(REF_CLK),
		.rst(RST),
		.rxd(TGT_RXD),
		.en(TGT_ENABLE),
		.div(s_r.div),
		.rx_out(rx_got)
	);

	// a new request only once the previous ack has dropped
	assign req = WB_CYC_I && WB_STB_I && !s_r.ack;
	assign wr = req && WB_WE_I;
	assign rd = req && !WB_WE_I;
	assign usb_sel = (WB_ADR_I == `SBU_OFS_USB);
	assign sock_sel = (WB_ADR_I == `SBU_OFS_SOCK);
	// only the active host path reaches the data registers
	assign path_sel = s_r.sock ? sock_sel : usb_sel; // R14

	// request-to-send only matters in the gating modes
	assign gate_on = (s_r.mode == sbu_pkg::SBU_HS_GATE) ||
		(s_r.mode == sbu_pkg::SBU_HS_BOTH); // R3
	assign tx_go = s_r.hold.vld && TGT_ENABLE &&
		(!gate_on || TGT_RTS); // R6 R8 R11 R12 R13

	// divisor request from the lower two byte lanes, clamped into range
	always_comb begin
		div_wr = {16'h0000, s_r.div};
		if (WB_SEL_I[0]) begin
			div_wr[7:0] = WB_DAT_I[7:0];
		end
		if (WB_SEL_I[1]) begin
			div_wr[15:8] = WB_DAT_I[15:8];
		end
		if (div_wr < `SBU_DIV_LO) begin // R2
			div_wr = `SBU_DIV_LO;
		end else if (div_wr > `SBU_DIV_HI) begin
			div_wr = `SBU_DIV_HI;
		end
	end

	always_comb begin
		stat = 32'h0000_0000;
		stat[`SBU_STAT_RXFULL] = s_r.rxb.vld;
		stat[`SBU_STAT_TXBUSY] = (s_r.tx_st != sbu_pkg::SBU_SER_IDLE);
		stat[`SBU_STAT_HOLD] = s_r.hold.vld;
		stat[`SBU_STAT_CTS] = s_r.cts_o;
		stat[`SBU_STAT_RTS] = TGT_RTS;
		stat[`SBU_STAT_OVR] = s_r.ovr;
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (WB_ADR_I)
			`SBU_OFS_CTRL: begin
				rd_val[`SBU_CTRL_MODE_LO +: 2] = s_r.mode;
				rd_val[`SBU_CTRL_SOCK] = s_r.sock;
			end
			`SBU_OFS_BAUD: begin
				rd_val[15:0] = s_r.div;
			end
			`SBU_OFS_STAT: begin
				rd_val = stat;
			end
			`SBU_OFS_USB, `SBU_OFS_SOCK: begin
				// the idle path reads as zero
				if (path_sel) begin // R14
					rd_val[7:0] = s_r.rxb.dat;
				end
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		s_nxt = s_r;

		// bus answer: one cycle after the request, every address acked
		s_nxt.ack = req;
		if (rd) begin
			s_nxt.dat_o = rd_val;
		end

		// control and baud writes
		if (wr && WB_ADR_I == `SBU_OFS_CTRL && WB_SEL_I[0]) begin
			s_nxt.mode = sbu_pkg::sbu_hs_e'(
				WB_DAT_I[`SBU_CTRL_MODE_LO +: 2]); // R3
			s_nxt.sock = WB_DAT_I[`SBU_CTRL_SOCK]; // R14
		end
		if (wr && WB_ADR_I == `SBU_OFS_BAUD && (|WB_SEL_I[1:0])) begin
			s_nxt.div = div_wr[15:0]; // R2
		end
		// writing a one to the overrun bit of the status word clears the overrun flag
		if (wr && WB_ADR_I == `SBU_OFS_STAT && WB_SEL_I[0] &&
			WB_DAT_I[`SBU_STAT_OVR]) begin
			s_nxt.ovr = 1'b0;
		end

		// host byte toward the target; refused while the holding slot is full
		if (wr && path_sel && WB_SEL_I[0] && !s_r.hold.vld) begin // R14
			s_nxt.hold.vld = 1'b1;
			s_nxt.hold.dat = WB_DAT_I[7:0];
		end

		// host read of the received byte empties the buffer
		if (rd && path_sel) begin // R14
			s_nxt.rxb.vld = 1'b0;
		end
		// arrival wins over a pop in the same cycle
		if (rx_got.vld) begin
			if (s_r.rxb.vld && !(rd && path_sel)) begin
				s_nxt.ovr = 1'b1;
			end else begin
				s_nxt.rxb.vld = 1'b1;
				s_nxt.rxb.dat = rx_got.dat;
			end
		end

		// transmitter toward the target
		case (s_r.tx_st)
			sbu_pkg::SBU_SER_IDLE: begin
				s_nxt.txd = 1'b1; // R16
				if (tx_go) begin // R6
					s_nxt.tx_st = sbu_pkg::SBU_SER_START;
					s_nxt.tx_shf = s_r.hold.dat;
					s_nxt.hold.vld = 1'b0;
					s_nxt.txd = 1'b0; // R16
					s_nxt.tx_cnt = s_r.div - 16'h0001;
				end
			end
			sbu_pkg::SBU_SER_START: begin
				// once started the byte runs out whatever the handshake does
				if (s_r.tx_cnt == 16'h0000) begin // R7
					s_nxt.tx_st = sbu_pkg::SBU_SER_DATA;
					s_nxt.txd = s_r.tx_shf[0]; // R16
					s_nxt.tx_bitn = 3'h0;
					s_nxt.tx_cnt = s_r.div - 16'h0001;
				end else begin
					s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				end
			end
			sbu_pkg::SBU_SER_DATA: begin
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_cnt = s_r.div - 16'h0001;
					s_nxt.tx_shf = s_r.tx_shf >> 1;
					if (s_r.tx_bitn == 3'h7) begin
						s_nxt.tx_st = sbu_pkg::SBU_SER_STOP;
						s_nxt.txd = 1'b1; // R16
					end else begin
						s_nxt.tx_bitn = s_r.tx_bitn + 3'h1;
						s_nxt.txd = s_r.tx_shf[1]; // R16
					end
				end else begin
					s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				end
			end
			sbu_pkg::SBU_SER_STOP: begin
				if (s_r.tx_cnt == 16'h0000) begin
					s_nxt.tx_st = sbu_pkg::SBU_SER_IDLE;
				end else begin
					s_nxt.tx_cnt = s_r.tx_cnt - 16'h0001;
				end
			end
			default: begin
				s_nxt.tx_st = sbu_pkg::SBU_SER_IDLE;
				s_nxt.txd = 1'b1;
			end
		endcase

		// clear-to-send follows the buffer state of the next cycle
		case (s_nxt.mode)
			sbu_pkg::SBU_HS_HOLD, sbu_pkg::SBU_HS_BOTH: begin
				s_nxt.cts_oe = 1'b1; // R10 R12
				s_nxt.cts_o = !s_nxt.rxb.vld; // R4 R5
			end
			sbu_pkg::SBU_HS_OFF, sbu_pkg::SBU_HS_GATE: begin
				s_nxt.cts_oe = 1'b0; // R9 R11
				s_nxt.cts_o = 1'b1;
			end
			default: begin
				s_nxt.cts_oe = 1'b0;
				s_nxt.cts_o = 1'b1;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			s_r <= '0;
			s_r.mode <= sbu_pkg::SBU_HS_OFF; // R1
			s_r.div <= 16'(`SBU_DIV_RST); // R1
			s_r.txd <= 1'b1;
			s_r.cts_o <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign WB_DAT_O = s_r.dat_o;
	assign WB_ACK_O = s_r.ack;
	assign TGT_TXD = s_r.txd;
	assign TGT_CTS_O = s_r.cts_o;
	assign TGT_CTS_OE = s_r.cts_oe;

endmodule

// *** sbu_consts.svh ***
// offsets, field positions, reset values and timing counts of the bridge
`ifndef SBU_CONSTS_SVH
`define SBU_CONSTS_SVH

`define SBU_CLK_HZ 32'd20_000_000
`define SBU_BAUD_DEF 32'd115_200
`define SBU_BAUD_MIN 32'd9_600
`define SBU_BAUD_MAX 32'd921_600
`define SBU_DIV_RST ((`SBU_CLK_HZ + (`SBU_BAUD_DEF / 32'd2)) / `SBU_BAUD_DEF)
`define SBU_DIV_LO (`SBU_CLK_HZ / `SBU_BAUD_MAX)
`define SBU_DIV_HI (`SBU_CLK_HZ / `SBU_BAUD_MIN)

`define SBU_OFS_CTRL 8'h00
`define SBU_OFS_BAUD 8'h04
`define SBU_OFS_STAT 8'h08
`define SBU_OFS_USB 8'h0C
`define SBU_OFS_SOCK 8'h10

`define SBU_CTRL_MODE_LO 0
`define SBU_CTRL_SOCK 2
`define SBU_CTRL_RST 32'h0000_0000

`define SBU_STAT_RXFULL 0
`define SBU_STAT_TXBUSY 1
`define SBU_STAT_HOLD 2
`define SBU_STAT_CTS 3
`define SBU_STAT_RTS 4
`define SBU_STAT_OVR 5

`endif

// *** sbu_pkg.sv ***
// types shared by the bridge modules
package sbu_pkg;

	typedef enum logic [1:0] {
		SBU_HS_OFF,
		SBU_HS_HOLD,
		SBU_HS_GATE,
		SBU_HS_BOTH
	} sbu_hs_e;

	typedef enum logic [1:0] {
		SBU_SER_IDLE,
		SBU_SER_START,
		SBU_SER_DATA,
		SBU_SER_STOP
	} sbu_ser_e;

	typedef struct packed {
		sbu_ser_e st;
		logic [15:0] cnt;
		logic [2:0] bitn;
		logic [7:0] shf;
		logic vld;
		logic [7:0] dat;
	} sbu_rx_s;

	typedef struct packed {
		logic vld;
		logic [7:0] dat;
	} sbu_byte_s;

	typedef struct packed {
		sbu_hs_e mode;
		logic sock;
		logic [15:0] div;
		sbu_ser_e tx_st;
		logic [15:0] tx_cnt;
		logic [2:0] tx_bitn;
		logic [7:0] tx_shf;
		logic txd;
		sbu_byte_s hold;
		sbu_byte_s rxb;
		logic ovr;
		logic ack;
		logic [31:0] dat_o;
		logic cts_o;
		logic cts_oe;
	} sbu_top_s;

endpackage

// *** sbu_rx.sv ***
// serial receiver: 8N1 framing sampled at mid bit
`timescale 1ns/100ps
module sbu_rx (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// line and control
	input wire logic rxd,
	input wire logic en,
	input wire logic [15:0] div,
	// received byte
	output sbu_pkg::sbu_byte_s rx_out
);

	sbu_pkg::sbu_rx_s s_r;
	sbu_pkg::sbu_rx_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.vld = 1'b0;
		case (s_r.st)
			sbu_pkg::SBU_SER_IDLE: begin
				// no new character is taken while the interface is off
				if (en && !rxd) begin // R13
					s_nxt.st = sbu_pkg::SBU_SER_START;
					s_nxt.cnt = div >> 1;
				end
			end
			sbu_pkg::SBU_SER_START: begin
				if (s_r.cnt == 16'h0000) begin
					// a glitch shorter than half a bit is dropped
					if (!rxd) begin // R16
						s_nxt.st = sbu_pkg::SBU_SER_DATA;
						s_nxt.cnt = div - 16'h0001;
						s_nxt.bitn = 3'h0;
					end else begin
						s_nxt.st = sbu_pkg::SBU_SER_IDLE;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 16'h0001;
				end
			end
			sbu_pkg::SBU_SER_DATA: begin
				if (s_r.cnt == 16'h0000) begin
					s_nxt.shf = {rxd, s_r.shf[7:1]}; // R16
					s_nxt.cnt = div - 16'h0001;
					if (s_r.bitn == 3'h7) begin
						s_nxt.st = sbu_pkg::SBU_SER_STOP;
					end else begin
						s_nxt.bitn = s_r.bitn + 3'h1;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 16'h0001;
				end
			end
			sbu_pkg::SBU_SER_STOP: begin
				if (s_r.cnt == 16'h0000) begin
					s_nxt.st = sbu_pkg::SBU_SER_IDLE;
					// a low stop bit is a framing error: byte discarded
					if (rxd) begin // R16
						s_nxt.vld = 1'b1;
						s_nxt.dat = s_r.shf;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 16'h0001;
				end
			end
			default: begin
				s_nxt.st = sbu_pkg::SBU_SER_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_out.vld = s_r.vld;
	assign rx_out.dat = s_r.dat;

endmodule

// *** sbu_bridge_props.sv ***
// checker for bus handshake, line timing and clear-to-send
`timescale 1ns/100ps
module sbu_bridge_props (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// link
	input wire logic TGT_TXD,
	input wire logic TGT_CTS_O,
	input wire logic TGT_CTS_OE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	property p_ack_take;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("ack late");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_ack_cause;
		$rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_dat_hold;
		!$stable(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_oe_mode;
		WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00
			|=> TGT_CTS_OE == $past(WB_DAT_I[0]);
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("cts drive");
	// pop taken while held off: clear-to-send is back one edge later
	property p_cts_back;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I &&
			WB_ADR_I == 8'h0c && TGT_CTS_OE && !TGT_CTS_O
			|=> TGT_CTS_O;
	endproperty
	a_cts_back: assert property (p_cts_back) else $error("cts stuck");
	// only a pop may free the buffer, so only a read may raise it
	property p_cts_rise;
		$rose(TGT_CTS_O) && TGT_CTS_OE |-> WB_ACK_O && !WB_WE_I;
	endproperty
	a_cts_rise: assert property (p_cts_rise) else $error("cts early");
	property p_bit_len;
		$fell(TGT_TXD) |-> (!TGT_TXD) [*8];
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("short bit");
endmodule

// *** sbu_tgt_model.sv ***
// target uart: sends bytes under clear-to-send, receives bytes
`timescale 1ns/100ps
module sbu_tgt_model (
	// clock and bit time
	input wire logic clk,
	input wire logic [15:0] div,
	// serial lines
	input wire logic txd,
	output logic rxd,
	input wire logic cts,
	input wire logic cts_oe,
	// received bytes
	output logic [7:0] rx_byte,
	output int rx_n
);
	initial begin
		rxd = 1'b1;
		rx_n = 0;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		while (cts_oe && !cts) @(negedge clk);
		@(posedge clk);
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (div) @(posedge clk);
		end
	endtask
	// always ready: one more byte after request drop is taken too
	always begin
		@(negedge txd);
		repeat (div / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(negedge clk);
			rx_byte[i] = txd;
		end
		repeat (div) @(negedge clk);
		if (txd === 1'b1) rx_n++;
	end
endmodule

// *** sbu_bridge_tb.sv ***
// self-checking bench for the serial bridge
`timescale 1ns/100ps
module sbu_bridge_tb;
	logic REF_CLK = 0, RST = 1, cyc = 0, stb = 0, we = 0, rts = 0, en = 1;
	logic [7:0] adr = 8'h00, b1, b2, rb;
	logic [31:0] dat = 32'h0000_0000, lf = 32'h0001_04b7, rdat;
	logic [15:0] div = 16'h00ae;
	logic ack, txd, cts, oe, rxd;
	int rn, n0, n_fail = 0, comparisons = 0;
	logic [7:0] exp_tx[$];
	logic [31:0] exp_rd[$];
	always #25 REF_CLK = ~REF_CLK;
	sbu_bridge u_sbu_bridge (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
		.WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TGT_RXD(rxd),
		.TGT_TXD(txd), .TGT_RTS(rts), .TGT_CTS_O(cts), .TGT_CTS_OE(oe),
		.TGT_ENABLE(en));
	sbu_tgt_model u_sbu_tgt_model (.clk(REF_CLK), .div(div), .txd(txd),
		.rxd(rxd), .cts(cts), .cts_oe(oe), .rx_byte(rb), .rx_n(rn));
	function logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] want, input string w);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", w, want, seen);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge REF_CLK); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task tx(input logic [7:0] a, input bit q);
		lf = nxt(lf);
		if (q) exp_tx.push_back(lf[7:0]);
		wb(1'b1, a, {24'h00_0000, lf[7:0]});
	endtask
	task gap(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge REF_CLK)
		if (ack === 1'b1 && we === 1'b0)
			chk(rdat, exp_rd.pop_front(), "read data");
	always @(rn)
		if (rn > 0)
			chk(rb, exp_tx.size() ? exp_tx.pop_front() : 8'hxx, "byte");
	initial begin
		gap(30000);
		n_fail++;
		finish_test;
	end
	initial begin
		gap(10);
		RST <= 1'b0;
		rd(8'h00, 32'h0000_0000);
		rd(8'h04, 32'h0000_00ae);
		rd(8'h20, 32'h0000_0000);
		tx(8'h0c, 1'b1);
		gap(12 * div);
		$display("defaults done");
		wb(1'b1, 8'h04, 32'h0000_0005);
		rd(8'h04, 32'h0000_0015);
		wb(1'b1, 8'h04, 32'h0000_ffff);
		rd(8'h04, 32'h0000_0823);
		wb(1'b1, 8'h04, 32'h0000_0015);
		div <= 16'h0015;
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, 8'h00, 32'(m));
			rd(8'h00, 32'(m));
		end
		$display("config done");
		wb(1'b1, 8'h00, 32'h0000_0002);
		n0 = rn;
		tx(8'h0c, 1'b1);
		gap(300);
		chk(rn, n0, "gated count");
		rts <= 1'b1;
		@(negedge txd);
		@(posedge REF_CLK);
		rts <= 1'b0;
		tx(8'h0c, 1'b1);
		// long enough that a leaking second byte would be counted
		gap(24 * div);
		chk(rn, n0 + 1, "count after drop");
		wb(1'b1, 8'h00, 32'h0000_0003);
		rts <= 1'b1;
		gap(12 * div);
		$display("gating done");
		wb(1'b1, 8'h00, 32'h0000_0001);
		rts <= 1'b0;
		lf = nxt(lf);
		b1 = lf[7:0];
		b2 = lf[15:8];
		u_sbu_tgt_model.send(b1);
		gap(4);
		chk(cts, 1'b0, "clear to send");
		rd(8'h08, 32'h0000_0001);
		fork
			u_sbu_tgt_model.send(b2);
		join_none
		gap(3 * div);
		rd(8'h0c, {24'h00_0000, b1});
		gap(12 * div);
		rd(8'h0c, {24'h00_0000, b2});
		tx(8'h0c, 1'b1);
		gap(12 * div);
		$display("hold-off done");
		wb(1'b1, 8'h00, 32'h0000_0000);
		en <= 1'b0;
		n0 = rn;
		tx(8'h0c, 1'b1);
		gap(300);
		chk(rn, n0, "disabled count");
		en <= 1'b1;
		gap(12 * div);
		wb(1'b1, 8'h00, 32'h0000_0004);
		tx(8'h0c, 1'b0);
		tx(8'h10, 1'b1);
		rd(8'h0c, 32'h0000_0000);
		gap(12 * div);
		$display("enable and socket done");
		chk(exp_tx.size(), 0, "pending bytes");
		finish_test;
	end
endmodule
bind sbu_bridge sbu_bridge_props u_sbu_bridge_props (.REF_CLK(REF_CLK),
	.RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .TGT_TXD(TGT_TXD), .TGT_CTS_O(TGT_CTS_O),
	.TGT_CTS_OE(TGT_CTS_OE));
